// >>> rtl/cis_defs.vh
`ifndef CIS_DEFS_VH
`define CIS_DEFS_VH

// Register byte offsets on the AXI4-Lite port.
`define CIS_A_CORE 8'h00
`define CIS_A_PFL1 8'h04
`define CIS_A_PFL2 8'h08
`define CIS_A_PEN1 8'h0c
`define CIS_A_PEN2 8'h10
`define CIS_A_OPT 8'h14
`define CIS_A_STAT 8'h18
`define CIS_A_CNT 8'h1c
// Shadow copies occupy 8'h20 to 8'h3c, one byte per word.
`define CIS_SHD_PAGE 3'h1

// Field positions in irq_core_control.
`define CIS_B_GIE 7
`define CIS_B_PERIPH_GROUP_ENABLE 6
`define CIS_B_TMR_EN 5
`define CIS_B_EXT_EN 4
`define CIS_B_CHG_EN 3
`define CIS_B_TMR_F 2
`define CIS_B_EXT_F 1
`define CIS_B_CHG_F 0
// Field position of ext_pin_edge_select in the option register.
`define CIS_B_EDGE 6

// Shadow word that holds the status register, and the mask of bits kept in it.
`define CIS_SHD_STATUS 1
`define CIS_STATUS_KEEP 8'he7

`define CIS_VECTOR 15'h0004

// Quadrature phases of one instruction cycle.
`define CIS_Q1 2'h0
`define CIS_Q4 2'h3

// Synchroniser fill count after reset before edges are believed.
`define CIS_SYNC_FILL 2'h3

`define CIS_RESP_OKAY 2'h0
`define CIS_RESP_SLVERR 2'h2

`endif

// >>> rtl/cis_pin_edge.v
`timescale 1ns/10ps
`include "cis_defs.vh"
module cis_pin_edge (
  input wire aclk, // Instruction logic clock.
  input wire aresetn, // Synchronous reset, active low.
  input wire pin_async, // Raw external interrupt pin.
  input wire rise_sel, // High selects rising edge, low falling.
  output reg edge_seen // One-cycle pulse on the selected edge.
);

  reg meta;
  reg stable;
  reg last;
  reg [1:0] warm;

  // Edges are ignored until both stages hold real pin samples, so a pin
  // that idles high gives no false edge after reset. The price is that an
  // edge in the first few cycles after reset is lost.
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
      edge_seen <= 1'b0;
      warm <= 2'h0;
    end else begin
      meta <= pin_async;
      stable <= meta;
      last <= stable;
      if (warm != `CIS_SYNC_FILL) begin
        warm <= warm + 2'h1;
      end
      edge_seen <= (warm == `CIS_SYNC_FILL) &&
                   (rise_sel ? (stable & ~last) : (~stable & last));
    end
  end

endmodule

// >>> rtl/cis_shadow_bank.v
`timescale 1ns/10ps
module cis_shadow_bank #(
  parameter WORDS = 8,
  parameter WIDTH = 8,
  parameter IDX_W = 3
) (
  input wire aclk, // Clock.
  input wire aresetn, // Synchronous reset, active low.
  input wire save, // Load every word at once.
  input wire [WORDS*WIDTH-1:0] save_data, // Words to load on save.
  input wire wr_en, // Write one word from software.
  input wire [IDX_W-1:0] wr_idx, // Word index for a software write.
  input wire [WIDTH-1:0] wr_data, // Software write data.
  output reg [WORDS*WIDTH-1:0] contents // All words, from flip-flops.
);

  // A context save wins over a software write in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      contents <= {WORDS*WIDTH{1'b0}};
    end else if (save) begin
      contents <= save_data;
    end else if (wr_en) begin
      contents[wr_idx*WIDTH +: WIDTH] <= wr_data;
    end
  end

endmodule

// >>> rtl/cis_top.v
`timescale 1ns/10ps
`include "cis_defs.vh"
module cis_top #(
  parameter PC_W = 15,
  parameter CTX_WORDS = 8
) (
  input wire aclk, // Clock, one quadrature phase per edge.
  input wire aresetn, // Synchronous reset, active low.
  input wire [7:0] awaddr, // AXI write address.
  input wire awvalid, // AXI write address valid.
  output wire awready, // AXI write address ready.
  input wire [31:0] wdata, // AXI write data.
  input wire [3:0] wstrb, // AXI write byte strobes.
  input wire wvalid, // AXI write data valid.
  output wire wready, // AXI write data ready.
  output reg [1:0] bresp, // AXI write response.
  output reg bvalid, // AXI write response valid.
  input wire bready, // AXI write response ready.
  input wire [7:0] araddr, // AXI read address.
  input wire arvalid, // AXI read address valid.
  output wire arready, // AXI read address ready.
  output reg [31:0] rdata, // AXI read data.
  output reg [1:0] rresp, // AXI read response.
  output reg rvalid, // AXI read data valid.
  input wire rready, // AXI read data ready.
  input wire ext_pin, // External interrupt pin, asynchronous.
  input wire timer_evt, // Core timer overflow pulse.
  input wire change_pend, // Pin-change summary level from port logic.
  input wire [7:0] periph_evt_one, // Peripheral event pulses, group one.
  input wire [7:0] periph_evt_two, // Peripheral event pulses, group two.
  input wire core_sleeping, // Core is in sleep.
  input wire return_from_handler, // Core executes handler return.
  input wire [PC_W-1:0] pc_now, // Program counter to be pushed.
  input wire [CTX_WORDS*8-1:0] ctx_live, // Live context words.
  output reg [1:0] q_phase, // Current quadrature phase.
  output wire irq_request, // Interrupt request level.
  output reg flush_prefetch, // Discard prefetched instruction.
  output reg stack_push, // Push push_addr onto the stack.
  output reg [PC_W-1:0] push_addr, // Return address.
  output reg pc_load, // Load pc_value into the PC.
  output reg [PC_W-1:0] pc_value, // Interrupt vector.
  output reg stack_pop, // Pop the return address.
  output reg ctx_restore, // Copy ctx_restore_data into the core.
  output wire [CTX_WORDS*8-1:0] ctx_restore_data, // Shadow words.
  output reg wake // Leave sleep.
);

  localparam S_IDLE = 2'h0;
  localparam S_FLUSH = 2'h1;
  localparam S_POST = 2'h2;

  reg [1:0] state;
  reg global_irq_enable;
  reg periph_group_enable;
  reg tmr_enable;
  reg ext_pin_irq_enable;
  reg chg_enable;
  reg tmr_flag;
  reg ext_pin_irq_flag;
  reg ext_hold;
  reg ext_pin_edge_select;
  reg [7:0] periph_flags_one;
  reg [7:0] periph_flags_two;
  reg [7:0] periph_enable_one;
  reg [7:0] periph_enable_two;
  reg [7:0] taken_count;
  reg aw_hold;
  reg [7:0] aw_addr;
  reg w_hold;
  reg [7:0] w_byte;
  reg w_lane;
  reg [7:0] rd_byte;
  reg rd_hit;
  reg [CTX_WORDS*8-1:0] save_words;

  wire q1;
  wire ext_phase_ok;
  wire ext_edge;
  wire ext_set;
  wire core_pend;
  wire periph_pend;
  wire any_pend;
  wire dispatch;
  wire do_write;
  wire wr_hit;
  wire wr_core;
  wire wr_shd;
  wire ctx_save;

  // Phase divider: each instruction cycle is four clock edges long.
  always @(posedge aclk) begin
    if (!aresetn) begin
      q_phase <= `CIS_Q1;
    end else begin
      q_phase <= q_phase + 2'h1;
    end
  end

  assign q1 = (q_phase == `CIS_Q1);

  cis_pin_edge u_pin (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_async(ext_pin),
    .rise_sel(ext_pin_edge_select),
    .edge_seen(ext_edge)
  );

  // Pin flag window Q4-Q1.
  // An edge seen in the middle phases is held until the window opens.
  assign ext_phase_ok = (q_phase == `CIS_Q4) || q1;
  assign ext_set = (ext_edge | ext_hold) & ext_phase_ok;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_hold <= 1'b0;
    end else begin
      ext_hold <= (ext_edge | ext_hold) & ~ext_phase_ok;
    end
  end

  assign core_pend = (tmr_enable & tmr_flag) |
                     (ext_pin_irq_enable & ext_pin_irq_flag) |
                     (chg_enable & change_pend);
  assign periph_pend = |(periph_flags_one & periph_enable_one) |
                       |(periph_flags_two & periph_enable_two);
  assign any_pend = core_pend | (periph_group_enable & periph_pend);
  assign irq_request = global_irq_enable & any_pend;

  // Fixed cadence, no instruction length.
  // The core's own decode never enters into this, so one- and two-cycle
  // instructions see the same latency.
  assign dispatch = q1 && (state != S_FLUSH) && irq_request &&
                    !(core_sleeping && state == S_IDLE);
  assign ctx_save = dispatch;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      flush_prefetch <= 1'b0;
      stack_push <= 1'b0;
      push_addr <= {PC_W{1'b0}};
      pc_load <= 1'b0;
      pc_value <= {PC_W{1'b0}};
      wake <= 1'b0;
      taken_count <= 8'h00;
    end else begin
      flush_prefetch <= 1'b0;
      stack_push <= 1'b0;
      pc_load <= 1'b0;
      wake <= 1'b0;
      if (q1) begin
        case (state)
          S_IDLE, S_POST: begin
            if (core_sleeping && state == S_IDLE) begin
              if (any_pend) begin
                wake <= 1'b1;
                state <= S_POST;
              end
            end else if (dispatch) begin
              flush_prefetch <= 1'b1;
              stack_push <= 1'b1;
              push_addr <= pc_now;
              taken_count <= taken_count + 8'h01;
              state <= S_FLUSH;
            end else begin
              state <= S_IDLE;
            end
          end
          S_FLUSH: begin
            pc_load <= 1'b1;
            pc_value <= `CIS_VECTOR;
            state <= S_IDLE;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      stack_pop <= 1'b0;
      ctx_restore <= 1'b0;
    end else begin
      stack_pop <= return_from_handler;
      ctx_restore <= return_from_handler;
    end
  end

  always @* begin
    save_words = ctx_live;
    save_words[`CIS_SHD_STATUS*8 +: 8] =
      ctx_live[`CIS_SHD_STATUS*8 +: 8] & `CIS_STATUS_KEEP;
  end

  cis_shadow_bank #(
    .WORDS(CTX_WORDS),
    .WIDTH(8),
    .IDX_W(3)
  ) u_shadow (
    .aclk(aclk),
    .aresetn(aresetn),
    .save(ctx_save),
    .save_data(save_words),
    .wr_en(wr_shd),
    .wr_idx(aw_addr[4:2]),
    .wr_data(w_byte),
    .contents(ctx_restore_data)
  );

  // AXI write channel: address and data are taken in either order.
  assign awready = ~aw_hold;
  assign wready = ~w_hold;
  assign do_write = aw_hold & w_hold & ~bvalid;
  assign wr_hit = (aw_addr[7:5] == `CIS_SHD_PAGE) ||
                  (aw_addr <= `CIS_A_CNT && aw_addr[1:0] == 2'h0);
  assign wr_core = do_write && w_lane && aw_addr == `CIS_A_CORE;
  assign wr_shd = do_write && w_lane && aw_addr[7:5] == `CIS_SHD_PAGE &&
                  aw_addr[1:0] == 2'h0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_hold <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `CIS_RESP_OKAY;
    end else begin
      if (awvalid && !aw_hold) begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && !w_hold) begin
        w_hold <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Reset clears all enables.
  // Hardware changes to the global enable win over a software write.
  always @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_enable <= 1'b0;
      periph_group_enable <= 1'b0;
      tmr_enable <= 1'b0;
      ext_pin_irq_enable <= 1'b0;
      chg_enable <= 1'b0;
      periph_enable_one <= 8'h00;
      periph_enable_two <= 8'h00;
      ext_pin_edge_select <= 1'b1;
    end else begin
      if (wr_core) begin
        global_irq_enable <= w_byte[`CIS_B_GIE];
        periph_group_enable <= w_byte[`CIS_B_PERIPH_GROUP_ENABLE];
        tmr_enable <= w_byte[`CIS_B_TMR_EN];
        ext_pin_irq_enable <= w_byte[`CIS_B_EXT_EN];
        chg_enable <= w_byte[`CIS_B_CHG_EN];
      end
      if (dispatch) begin
        global_irq_enable <= 1'b0;
      end else if (return_from_handler) begin
        global_irq_enable <= 1'b1;
      end
      if (do_write && w_lane && aw_addr == `CIS_A_PEN1) begin
        periph_enable_one <= w_byte;
      end
      if (do_write && w_lane && aw_addr == `CIS_A_PEN2) begin
        periph_enable_two <= w_byte;
      end
      if (do_write && w_lane && aw_addr == `CIS_A_OPT) begin
        ext_pin_edge_select <= w_byte[`CIS_B_EDGE];
      end
    end
  end

  // Pin edge sets flag.
  // An event in the cycle of a software clear still sets its flag.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tmr_flag <= 1'b0;
      ext_pin_irq_flag <= 1'b0;
      periph_flags_one <= 8'h00;
      periph_flags_two <= 8'h00;
    end else begin
      tmr_flag <= (wr_core ? w_byte[`CIS_B_TMR_F] : tmr_flag) | timer_evt;
      ext_pin_irq_flag <= (wr_core ? w_byte[`CIS_B_EXT_F] :
                           ext_pin_irq_flag) | ext_set;
      periph_flags_one <= ((do_write && w_lane &&
                            aw_addr == `CIS_A_PFL1) ?
                           w_byte : periph_flags_one) | periph_evt_one;
      periph_flags_two <= ((do_write && w_lane &&
                            aw_addr == `CIS_A_PFL2) ?
                           w_byte : periph_flags_two) | periph_evt_two;
    end
  end

  // Read decode; the pin-change flag is the live summary from the port.
  always @* begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (araddr[7:5] == `CIS_SHD_PAGE && araddr[1:0] == 2'h0) begin
      rd_byte = ctx_restore_data[{araddr[4:2], 3'h0} +: 8];
    end else begin
      case (araddr)
        `CIS_A_CORE: rd_byte = {global_irq_enable, periph_group_enable,
                                tmr_enable, ext_pin_irq_enable, chg_enable,
                                tmr_flag, ext_pin_irq_flag, change_pend};
        `CIS_A_PFL1: rd_byte = periph_flags_one;
        `CIS_A_PFL2: rd_byte = periph_flags_two;
        `CIS_A_PEN1: rd_byte = periph_enable_one;
        `CIS_A_PEN2: rd_byte = periph_enable_two;
        `CIS_A_OPT: rd_byte = {1'b0, ext_pin_edge_select, 6'h00};
        `CIS_A_STAT: rd_byte = {irq_request, any_pend, core_sleeping,
                                1'b0, state, q_phase};
        `CIS_A_CNT: rd_byte = taken_count;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  assign arready = ~rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `CIS_RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= rd_hit ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// >>> tb/cis_core_model.sv
`timescale 1ns/10ps
// Core stand-in: the PC advances while awake, one stack level is enough
// because the bench never nests handlers.
module cis_core_model (
  input wire aclk, // Clock.
  input wire aresetn, // Reset, active low.
  input wire go_sleep, // Bench command to sleep.
  input wire go_ret, // Bench command to return.
  input wire stack_push, // Push pulse.
  input wire [14:0] push_addr, // Pushed address.
  input wire pc_load, // Vector load pulse.
  input wire [14:0] pc_value, // Vector.
  input wire stack_pop, // Pop pulse.
  input wire wake, // Wake pulse.
  output reg [14:0] pc_now, // Program counter.
  output reg core_sleeping, // Sleep level.
  output reg return_from_handler // Return pulse.
);
  reg [14:0] top;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pc_now <= 15'h0100;
      top <= 15'h0000;
      core_sleeping <= 1'b0;
      return_from_handler <= 1'b0;
    end else begin
      return_from_handler <= go_ret;
      if (go_sleep)
        core_sleeping <= 1'b1;
      else if (wake)
        core_sleeping <= 1'b0;
      if (stack_push)
        top <= push_addr;
      if (pc_load)
        pc_now <= pc_value;
      else if (stack_pop)
        pc_now <= top;
      else if (!core_sleeping)
        pc_now <= pc_now + 15'h0001;
    end
  end
endmodule

// >>> tb/cis_top_sva.sv
`timescale 1ns/10ps
module cis_top_sva #(
  parameter PC_W = 15
) (
  input wire aclk, // Clock.
  input wire aresetn, // Reset, active low.
  input wire [1:0] q_phase, // Phase.
  input wire irq_request, // Request level.
  input wire flush_prefetch, // Flush pulse.
  input wire stack_push, // Push pulse.
  input wire [PC_W-1:0] push_addr, // Pushed address.
  input wire [PC_W-1:0] pc_now, // Live PC.
  input wire pc_load, // Vector load.
  input wire [PC_W-1:0] pc_value, // Vector.
  input wire return_from_handler, // Return pulse.
  input wire stack_pop, // Pop pulse.
  input wire ctx_restore, // Restore pulse.
  input wire wake, // Wake pulse.
  input wire core_sleeping // Sleep level.
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_taken;
    $past(irq_request) && $past(q_phase) == 2'h0 && stack_push;
  endsequence
  sequence s_vector;
    ##4 pc_load && pc_value == 15'h0004;
  endsequence
  a_flush_cause: assert property (
    flush_prefetch |-> s_taken) else $error("flush without request");
  a_push_pc: assert property (
    flush_prefetch |-> push_addr == $past(pc_now)) else $error("bad push");
  a_vector_load: assert property (
    flush_prefetch |-> s_vector) else $error("vector not loaded");
  a_vector_only: assert property (
    pc_load |-> $past(flush_prefetch, 4)) else $error("stray load");
  a_global_cleared: assert property (
    flush_prefetch |-> !irq_request) else $error("global kept");
  a_return_pops: assert property (
    return_from_handler |=> stack_pop && ctx_restore)
    else $error("no pop");
  a_pop_cause: assert property (
    stack_pop |-> $past(return_from_handler)) else $error("stray pop");
  a_wake_cause: assert property (
    wake |-> $past(core_sleeping) && $past(q_phase) == 2'h0)
    else $error("stray wake");
  a_reset_quiet: assert property (
    $rose(aresetn) |-> !irq_request && !flush_prefetch && q_phase == 2'h0)
    else $error("reset not quiet");
endmodule
bind cis_top cis_top_sva #(.PC_W(PC_W)) sva_u (.aclk, .aresetn, .q_phase,
  .irq_request, .flush_prefetch, .stack_push, .push_addr, .pc_now, .pc_load,
  .pc_value, .return_from_handler, .stack_pop, .ctx_restore, .wake,
  .core_sleeping);

// >>> tb/cis_top_tb_top.sv
`timescale 1ns/10ps
module cis_top_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ext_pin = 1'b0, timer_evt = 1'b0;
  logic go_sleep = 1'b0, go_ret = 1'b0;
  logic [7:0] periph_evt_one = 8'h00;
  logic [7:0] periph_evt_two = 8'h00;
  logic change_pend = 1'b0;
  logic [63:0] ctx_live = 64'h07060504_0302ff5a;
  wire awready, wready, bvalid, arready, rvalid, irq_request, flush_prefetch;
  wire stack_push, pc_load, stack_pop, ctx_restore, wake, core_sleeping;
  wire return_from_handler;
  wire [1:0] bresp, rresp, q_phase;
  wire [31:0] rdata;
  wire [14:0] push_addr, pc_value, pc_now;
  wire [63:0] ctx_restore_data;
  int n_mismatch = 0;
  int checks_done = 0;
  int n, sel;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [1:0] ws;
  cis_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ext_pin,
    .timer_evt, .change_pend, .periph_evt_one, .periph_evt_two,
    .core_sleeping, .return_from_handler, .pc_now, .ctx_live, .q_phase,
    .irq_request, .flush_prefetch, .stack_push, .push_addr, .pc_load,
    .pc_value, .stack_pop, .ctx_restore, .ctx_restore_data, .wake);
  cis_core_model core_u (.aclk, .aresetn, .go_sleep, .go_ret, .stack_push,
    .push_addr, .pc_load, .pc_value, .stack_pop, .wake, .pc_now,
    .core_sleeping, .return_from_handler);
  initial begin
    forever #4 aclk = ~aclk;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bail(input int i);
    if (i >= 100) begin
      n_mismatch++;
      $display("[FAIL] wait expected answer seen none");
      finish_test();
    end
  endtask
  // Handshakes are judged on values held since the last rising edge.
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    i = 0;
    do begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      ws = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      i++;
    end while (!tb && i < 100);
    bready <= 1'b0;
    bail(i);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ta, tr;
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    i = 0;
    do begin
      @(negedge aclk);
      ta = arready;
      tr = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      i++;
    end while (!tr && i < 100);
    rready <= 1'b0;
    bail(i);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, logic [31:0] e);
    axi_rd(a);
    check(nm, rd, e);
  endtask
  task automatic wait_sig(input int k, output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c++;
    end while (!(k == 0 ? flush_prefetch : k == 1 ? wake : pc_load) && c < 100);
    bail(c);
    @(posedge aclk);
  endtask
  task automatic pulse(input int k);
    if (k == 0)
      timer_evt <= 1'b1;
    else if (k == 1)
      go_ret <= 1'b1;
    else
      go_sleep <= 1'b1;
    @(posedge aclk);
    timer_evt <= 1'b0;
    go_ret <= 1'b0;
    go_sleep <= 1'b0;
    @(posedge aclk);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("core", 8'h00, 32'h0);
    rd_chk("option", 8'h14, 32'h40);
    axi_rd(8'hfc);
    check("unmapped", rs, 32'h2);
    axi_wr(8'hfc, 8'h01);
    check("unmapped wr", ws, 32'h2);
    pulse(0);
    rd_chk("timer flag", 8'h00, 32'h04);
    axi_wr(8'h00, 8'h24);
    check("write okay", ws, 32'h0);
    @(negedge aclk);
    check("held off", irq_request, 32'h0);
    axi_wr(8'h00, 8'ha4);
    wait_sig(0, n);
    rd_chk("global off", 8'h00, 32'h24);
    rd_chk("shadow status", 8'h24, 32'he7);
    axi_wr(8'h20, 8'h3c);
    axi_wr(8'h00, 8'h20);
    pulse(1);
    check("restored w", ctx_restore_data[7:0], 32'h3c);
    rd_chk("global on", 8'h00, 32'ha0);
    rd_chk("taken", 8'h1c, 32'h1);
    pulse(0);
    wait_sig(2, n);
    check("latency", n <= 14, 32'h1);
    axi_wr(8'h00, 8'h20);
    pulse(1);
    axi_wr(8'h0c, 8'h08);
    axi_wr(8'h10, 8'h01);
    periph_evt_one <= 8'h08;
    periph_evt_two <= 8'h01;
    @(posedge aclk);
    periph_evt_one <= 8'h00;
    periph_evt_two <= 8'h00;
    rd_chk("periph flag", 8'h04, 32'h08);
    rd_chk("periph flag two", 8'h08, 32'h01);
    @(negedge aclk);
    check("group gate", irq_request, 32'h0);
    axi_wr(8'h00, 8'he0);
    wait_sig(0, n);
    axi_wr(8'h04, 8'h00);
    axi_wr(8'h08, 8'h00);
    axi_wr(8'h00, 8'h00);
    for (sel = 0; sel < 2; sel++) begin
      axi_wr(8'h14, sel[0] ? 8'h40 : 8'h00);
      ext_pin <= sel[0];
      repeat (8) @(posedge aclk);
      axi_wr(8'h00, 8'h00);
      ext_pin <= !sel[0];
      repeat (8) @(posedge aclk);
      rd_chk("wrong edge", 8'h00, 32'h0);
      ext_pin <= sel[0];
      repeat (8) @(posedge aclk);
      rd_chk("right edge", 8'h00, 32'h02);
    end
    axi_wr(8'h00, 8'h92);
    wait_sig(0, n);
    axi_wr(8'h00, 8'h20);
    axi_wr(8'h00, 8'ha0);
    pulse(2);
    pulse(0);
    wait_sig(1, n);
    wait_sig(0, n);
    check("post sleep gap", n, 32'h4);
    axi_wr(8'h00, 8'h08);
    change_pend <= 1'b1;
    rd_chk("change flag", 8'h00, 32'h09);
    axi_wr(8'h00, 8'h88);
    wait_sig(0, n);
    change_pend <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("reset again", 8'h00, 32'h0);
    finish_test();
  end
endmodule
